// ==== boiler_statistics_status_regs.sv ====
// Contract
// - Pump cycle counters are 32-bit values over two consecutive word registers, read and written by the master, 0 to 999,999.
// - The auxiliary pump cycle counter is a writable pair at 0x8c-0x8d limited to 0 to 999,999.
// - The second auxiliary pump cycle counter is a pair at 0x92-0x93 holding 0 to 999,999.
// - Word 0x95 reads the remaining boiler pump start delay and is read-only.
// - Word 0x96 reads the remaining system pump start delay and is read-only.
// - Words 0x94 and 0x97 read the remaining start delays of the second and first auxiliary pumps.
// - Word 0x9a reads the exchanger temperature change rate in tenths of a degree per second.
// - Word 0x9b reads the seconds the tap demand has been continuously recognised.
// - Word 0x9c reads the running time in seconds of the current tap heat demand.
`default_nettype none
module boiler_statistics_status_regs (
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire logic REQ_I,
  input wire logic WE_I,
  input wire logic [15:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  output logic ACK_O,
  output logic ERR_O,
  output logic [15:0] RDATA_O,
  input wire logic BURNER_CYCLE_I,
  input wire logic BURNER_HOUR_I,
  input wire logic CONTROLLER_CYCLE_I,
  input wire logic CONTROLLER_HOUR_I,
  input wire logic CENTRAL_HEATING_PUMP_START_I,
  input wire logic HOT_WATER_PUMP_START_I,
  input wire logic SYSTEM_PUMP_START_I,
  input wire logic BOILER_PUMP_START_I,
  input wire logic AUX_PUMP_START_I,
  input wire logic AUX2_PUMP_START_I,
  input wire logic [15:0] AUX2_START_DELAY_I,
  input wire logic [15:0] BOILER_START_DELAY_I,
  input wire logic [15:0] SYSTEM_START_DELAY_I,
  input wire logic [15:0] AUX1_START_DELAY_I,
  input wire logic TAP_DEMAND_I,
  input wire logic PREHEAT_DEMAND_I,
  input wire logic [15:0] CHANGE_RATE_I,
  input wire logic [15:0] TAP_RECOGNITION_I,
  input wire logic [15:0] TAP_ON_TIME_I
);
  localparam int N = boiler_stats_pkg::NUM_COUNTERS;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
    // high word of a pending double-word write
    logic stage_vld;
    logic [3:0] stage_idx;
    logic [15:0] stage;
    // low word captured when the high word was read
    logic snap_vld;
    logic [3:0] snap_idx;
    logic [15:0] snap;
  } regs_t;

  regs_t state_r;
  regs_t state_nxt;

  logic [N-1:0] inc;
  logic [N-1:0] load;
  logic [31:0] load_val;
  logic [31:0] count [N];

  function automatic logic in_counters(input logic [15:0] a);
    in_counters = (a >= boiler_stats_pkg::COUNTER_BASE) && (a <= boiler_stats_pkg::COUNTER_LAST);
  endfunction

  function automatic logic [3:0] counter_index(input logic [15:0] a);
    logic [15:0] off;
    off = a - boiler_stats_pkg::COUNTER_BASE;
    counter_index = off[4:1];
  endfunction

  // the lower address of each pair carries the high half
  function automatic logic is_high_half(input logic [15:0] a);
    is_high_half = (a[0] == boiler_stats_pkg::COUNTER_BASE[0]);
  endfunction

  function automatic logic [31:0] limit_of(input logic [3:0] i);
    if ((i == boiler_stats_pkg::IDX_BURNER_HOURS) || (i == boiler_stats_pkg::IDX_CONTROLLER_HOURS)) begin
      limit_of = boiler_stats_pkg::HOURS_MAX;
    end else begin
      limit_of = boiler_stats_pkg::CYCLE_COUNT_MAX;
    end
  endfunction

  always_comb begin
    inc = '0;
    inc[boiler_stats_pkg::IDX_BURNER_CYCLES] = BURNER_CYCLE_I;
    inc[boiler_stats_pkg::IDX_BURNER_HOURS] = BURNER_HOUR_I;
    inc[boiler_stats_pkg::IDX_CENTRAL_HEATING_PUMP] = CENTRAL_HEATING_PUMP_START_I;
    inc[boiler_stats_pkg::IDX_HOT_WATER_PUMP] = HOT_WATER_PUMP_START_I;
    inc[boiler_stats_pkg::IDX_SYSTEM_PUMP] = SYSTEM_PUMP_START_I;
    inc[boiler_stats_pkg::IDX_BOILER_PUMP] = BOILER_PUMP_START_I;
    inc[boiler_stats_pkg::IDX_AUX_PUMP] = AUX_PUMP_START_I;
    inc[boiler_stats_pkg::IDX_CONTROLLER_CYCLES] = CONTROLLER_CYCLE_I;
    inc[boiler_stats_pkg::IDX_CONTROLLER_HOURS] = CONTROLLER_HOUR_I;
    inc[boiler_stats_pkg::IDX_AUX2_PUMP] = AUX2_PUMP_START_I;
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cnt
      stat_counter #(
        .MAX(limit_of(4'(g)))
      ) u_cnt (
        .clk_i(CLOCK_I),
        .rst_n_i(NRST_I),
        .inc_i(inc[g]),
        .load_i(load[g]),
        .load_val_i(load_val),
        .count_o(count[g])
      );
    end
  endgenerate

  // status words: plain reads of live inputs, so nothing here can be written
  function automatic logic status_word(input logic [15:0] a, output logic [15:0] v);
    v = boiler_stats_pkg::WORD_ZERO;
    status_word = 1'b1;
    case (a)
      boiler_stats_pkg::ADDR_AUX2_START_DELAY: v = AUX2_START_DELAY_I;
      boiler_stats_pkg::ADDR_BOILER_START_DELAY: v = BOILER_START_DELAY_I;
      boiler_stats_pkg::ADDR_SYSTEM_START_DELAY: v = SYSTEM_START_DELAY_I;
      boiler_stats_pkg::ADDR_AUX1_START_DELAY: v = AUX1_START_DELAY_I;
      boiler_stats_pkg::ADDR_TAP_DEMAND: begin
        v = TAP_DEMAND_I ? boiler_stats_pkg::FLAG_ON : boiler_stats_pkg::FLAG_OFF;
      end
      boiler_stats_pkg::ADDR_PREHEAT_DEMAND: begin
        v = PREHEAT_DEMAND_I ? boiler_stats_pkg::FLAG_ON : boiler_stats_pkg::FLAG_OFF;
      end
      boiler_stats_pkg::ADDR_CHANGE_RATE: v = CHANGE_RATE_I;
      boiler_stats_pkg::ADDR_TAP_RECOGNITION: v = TAP_RECOGNITION_I;
      boiler_stats_pkg::ADDR_TAP_ON_TIME: v = TAP_ON_TIME_I;
      default: status_word = 1'b0;
    endcase
  endfunction

  always_comb begin
    logic [3:0] idx;
    logic hi;
    logic [31:0] cur;
    logic [31:0] cand;
    logic [15:0] sv;
    logic is_status;
    idx = counter_index(ADDR_I);
    hi = is_high_half(ADDR_I);
    cur = count[idx];
    cand = boiler_stats_pkg::COUNT_RESET;
    sv = boiler_stats_pkg::WORD_ZERO;
    is_status = status_word(ADDR_I, sv);
    state_nxt = state_r;
    state_nxt.ack = 1'b0;
    state_nxt.err = 1'b0;
    load = '0;
    load_val = boiler_stats_pkg::COUNT_RESET;

    if (REQ_I) begin
      state_nxt.ack = 1'b1;
      state_nxt.rdata = boiler_stats_pkg::WORD_ZERO;
      if (in_counters(ADDR_I)) begin
        if (!WE_I) begin
          if (hi) begin
            state_nxt.rdata = cur[31:16];
            // keep the low half so a following low read pairs with this one
            state_nxt.snap_vld = 1'b1;
            state_nxt.snap_idx = idx;
            state_nxt.snap = cur[15:0];
          end else if (state_r.snap_vld && (state_r.snap_idx == idx)) begin
            state_nxt.rdata = state_r.snap;
            state_nxt.snap_vld = 1'b0;
          end else begin
            state_nxt.rdata = cur[15:0];
          end
        end else if (idx == boiler_stats_pkg::IDX_CONTROLLER_HOURS) begin
          state_nxt.err = 1'b1;
        end else if (hi) begin
          // the high half waits for its low half so the pair changes at once
          state_nxt.stage_vld = 1'b1;
          state_nxt.stage_idx = idx;
          state_nxt.stage = WDATA_I;
        end else begin
          if (state_r.stage_vld && (state_r.stage_idx == idx)) begin
            cand = {state_r.stage, WDATA_I};
          end else begin
            cand = {cur[31:16], WDATA_I};
          end
          state_nxt.stage_vld = 1'b0;
          if (cand <= limit_of(idx)) begin
            load[idx] = 1'b1;
            load_val = cand;
          end else begin
            state_nxt.err = 1'b1;
          end
        end
      end else if (is_status) begin
        if (WE_I) begin
          state_nxt.err = 1'b1;
        end else begin
          state_nxt.rdata = sv;
        end
      end else begin
        state_nxt.err = 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign ACK_O = state_r.ack;
  assign ERR_O = state_r.err;
  assign RDATA_O = state_r.rdata;
endmodule
`default_nettype wire

// ==== boiler_stats_pkg.sv ====
`default_nettype none
package boiler_stats_pkg;
  localparam int WORD_W = 16;
  localparam int DWORD_W = 32;
  localparam int ADDR_W = 16;
  localparam int IDX_W = 4;

  // the statistics block is ten double words, each a pair of word addresses
  localparam int NUM_COUNTERS = 10;
  localparam logic [ADDR_W-1:0] COUNTER_BASE = 16'h0080;
  localparam logic [ADDR_W-1:0] COUNTER_LAST = 16'h0093;

  // counter index = (address - base) / 2
  localparam logic [IDX_W-1:0] IDX_BURNER_CYCLES = 4'h0;
  localparam logic [IDX_W-1:0] IDX_BURNER_HOURS = 4'h1;
  localparam logic [IDX_W-1:0] IDX_CENTRAL_HEATING_PUMP = 4'h2;
  localparam logic [IDX_W-1:0] IDX_HOT_WATER_PUMP = 4'h3;
  localparam logic [IDX_W-1:0] IDX_SYSTEM_PUMP = 4'h4;
  localparam logic [IDX_W-1:0] IDX_BOILER_PUMP = 4'h5;
  localparam logic [IDX_W-1:0] IDX_AUX_PUMP = 4'h6;
  localparam logic [IDX_W-1:0] IDX_CONTROLLER_CYCLES = 4'h7;
  localparam logic [IDX_W-1:0] IDX_CONTROLLER_HOURS = 4'h8;
  localparam logic [IDX_W-1:0] IDX_AUX2_PUMP = 4'h9;

  localparam logic [ADDR_W-1:0] ADDR_BURNER_CYCLES = 16'h0080;
  localparam logic [ADDR_W-1:0] ADDR_BURNER_HOURS = 16'h0082;
  localparam logic [ADDR_W-1:0] ADDR_CENTRAL_HEATING_PUMP = 16'h0084;
  localparam logic [ADDR_W-1:0] ADDR_HOT_WATER_PUMP = 16'h0086;
  localparam logic [ADDR_W-1:0] ADDR_SYSTEM_PUMP = 16'h0088;
  localparam logic [ADDR_W-1:0] ADDR_BOILER_PUMP = 16'h008a;
  localparam logic [ADDR_W-1:0] ADDR_AUX_PUMP = 16'h008c;
  localparam logic [ADDR_W-1:0] ADDR_CONTROLLER_CYCLES = 16'h008e;
  localparam logic [ADDR_W-1:0] ADDR_CONTROLLER_HOURS = 16'h0090;
  localparam logic [ADDR_W-1:0] ADDR_AUX2_PUMP = 16'h0092;

  localparam logic [ADDR_W-1:0] ADDR_AUX2_START_DELAY = 16'h0094;
  localparam logic [ADDR_W-1:0] ADDR_BOILER_START_DELAY = 16'h0095;
  localparam logic [ADDR_W-1:0] ADDR_SYSTEM_START_DELAY = 16'h0096;
  localparam logic [ADDR_W-1:0] ADDR_AUX1_START_DELAY = 16'h0097;
  localparam logic [ADDR_W-1:0] ADDR_TAP_DEMAND = 16'h0098;
  localparam logic [ADDR_W-1:0] ADDR_PREHEAT_DEMAND = 16'h0099;
  localparam logic [ADDR_W-1:0] ADDR_CHANGE_RATE = 16'h009a;
  localparam logic [ADDR_W-1:0] ADDR_TAP_RECOGNITION = 16'h009b;
  localparam logic [ADDR_W-1:0] ADDR_TAP_ON_TIME = 16'h009c;

  localparam logic [DWORD_W-1:0] CYCLE_COUNT_MAX = 32'h000f423f;
  localparam logic [DWORD_W-1:0] HOURS_MAX = 32'hffffffff;
  localparam logic [DWORD_W-1:0] COUNT_RESET = 32'h00000000;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [WORD_W-1:0] FLAG_OFF = 16'h0000;
  localparam logic [WORD_W-1:0] FLAG_ON = 16'h0001;
  localparam logic [IDX_W-1:0] IDX_ZERO = 4'h0;
endpackage
`default_nettype wire

// ==== stat_counter.sv ====
`default_nettype none
module stat_counter #(
  parameter logic [31:0] MAX = 32'h000f423f
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic inc_i,
  input wire logic load_i,
  input wire logic [31:0] load_val_i,
  output logic [31:0] count_o
);
  typedef struct packed {
    logic [31:0] count;
  } cnt_state_t;

  cnt_state_t state_r;
  cnt_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    // a master load wins over an event in the same cycle
    if (load_i) begin
      state_nxt.count = load_val_i;
    end else if (inc_i && (state_r.count < MAX)) begin
      // saturate rather than wrap so the figure never jumps back to zero
      state_nxt.count = state_r.count + 32'h00000001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign count_o = state_r.count;
endmodule
`default_nettype wire

// ==== boiler_regs_assertions.sv ====
`default_nettype none
module boiler_regs_checker (
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire logic REQ_I,
  input wire logic WE_I,
  input wire logic [15:0] ADDR_I,
  input wire logic ACK_O,
  input wire logic ERR_O,
  input wire logic [15:0] RDATA_O,
  input wire logic [15:0] BOILER_START_DELAY_I,
  input wire logic TAP_DEMAND_I,
  input wire logic [15:0] CHANGE_RATE_I
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);
  logic rd;
  logic wr;
  assign rd = REQ_I && !WE_I;
  assign wr = REQ_I && WE_I;
  ack_next_a: assert property (REQ_I |=> ACK_O)
    else $error("request not answered in the next cycle");
  err_with_ack_a: assert property (ERR_O |-> ACK_O)
    else $error("refusal without answer strobe");
  delay_ro_a: assert property (wr && ADDR_I inside {[16'h0094:16'h0097]} |=> ERR_O)
    else $error("write to start delay word not refused");
  flag_ro_a: assert property (wr && ADDR_I inside {[16'h0098:16'h009c]} |=> ERR_O)
    else $error("write to exchanger status word not refused");
  hours_ro_a: assert property (wr && ADDR_I[15:1] == 15'h0048 |=> ERR_O)
    else $error("write to controller run hours not refused");
  boiler_delay_a: assert property (rd && ADDR_I == 16'h0095 |=> !ERR_O && RDATA_O == $past(BOILER_START_DELAY_I))
    else $error("boiler pump start delay read wrong");
  tap_flag_a: assert property (rd && ADDR_I == 16'h0098 |=> RDATA_O == {15'h0000, $past(TAP_DEMAND_I)})
    else $error("tap demand flag read wrong");
  rate_read_a: assert property (rd && ADDR_I == 16'h009a |=> RDATA_O == $past(CHANGE_RATE_I))
    else $error("change rate read wrong");
  // the reset edge itself may clear read data, so only judge cycles that follow a running one
  rdata_hold_a: assert property (!ACK_O && $past(NRST_I) |-> $stable(RDATA_O))
    else $error("read data moved without answer");
endmodule
bind boiler_statistics_status_regs boiler_regs_checker i_boiler_regs_checker (.CLOCK_I, .NRST_I, .REQ_I, .WE_I,
  .ADDR_I, .ACK_O, .ERR_O, .RDATA_O, .BOILER_START_DELAY_I, .TAP_DEMAND_I, .CHANGE_RATE_I);
`default_nettype wire

// ==== modbus_master_model.sv ====
`default_nettype none
module modbus_master_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic err_i,
  input wire logic [15:0] rdata_i,
  output logic req_o,
  output logic we_o,
  output logic [15:0] addr_o,
  output logic [15:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    addr_o = 16'h0000;
    wdata_o = 16'h0000;
  end
  // qualifiers turn to inverted junk once released, so a stale address never looks valid
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic e, output logic ok);
    ok = 1'b0;
    q = 16'h0000;
    e = 1'b0;
    @(negedge clk_i);
    req_o = 1'b1;
    we_o = w;
    addr_o = a;
    wdata_o = d;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(negedge clk_i);
      req_o = 1'b0;
      we_o = ~w;
      addr_o = ~a;
      wdata_o = ~d;
      if (ack_i === 1'b1) begin
        ok = 1'b1;
        q = rdata_i;
        e = err_i;
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== boiler_statistics_status_regs_bench.sv ====
`default_nettype none
module boiler_statistics_status_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req, we, ack, err, e, ok;
  logic [15:0] addr, wdata, rdata, q;
  logic [15:0] sv [9];
  logic [9:0] ev = 10'h000;
  int errors = 0;
  int total_checks = 0;
  always #50 clk = ~clk;
  boiler_statistics_status_regs i_boiler_statistics_status_regs (.CLOCK_I(clk), .NRST_I(rst_n), .REQ_I(req),
    .WE_I(we), .ADDR_I(addr), .WDATA_I(wdata), .ACK_O(ack), .ERR_O(err), .RDATA_O(rdata),
    .BURNER_CYCLE_I(ev[0]), .BURNER_HOUR_I(ev[1]), .CENTRAL_HEATING_PUMP_START_I(ev[2]),
    .HOT_WATER_PUMP_START_I(ev[3]), .SYSTEM_PUMP_START_I(ev[4]), .BOILER_PUMP_START_I(ev[5]),
    .AUX_PUMP_START_I(ev[6]), .CONTROLLER_CYCLE_I(ev[7]), .CONTROLLER_HOUR_I(ev[8]), .AUX2_PUMP_START_I(ev[9]),
    .AUX2_START_DELAY_I(sv[0]), .BOILER_START_DELAY_I(sv[1]), .SYSTEM_START_DELAY_I(sv[2]),
    .AUX1_START_DELAY_I(sv[3]), .TAP_DEMAND_I(sv[4][0]), .PREHEAT_DEMAND_I(sv[5][0]), .CHANGE_RATE_I(sv[6]),
    .TAP_RECOGNITION_I(sv[7]), .TAP_ON_TIME_I(sv[8]));
  modbus_master_model i_modbus_master_model (.clk_i(clk), .ack_i(ack), .err_i(err), .rdata_i(rdata),
    .req_o(req), .we_o(we), .addr_o(addr), .wdata_o(wdata));
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input string n, input logic [15:0] x, input logic [15:0] g);
    total_checks++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    i_modbus_master_model.xfer(w, a, d, q, e, ok);
    if (!ok) begin
      errors++;
      $display("CHECK FAILED answer at %h expected 1 seen 0", a);
      print_verdict();
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] x);
    acc(1'b0, a, 16'h0000);
    cmp($sformatf("read %h", a), x, q);
    cmp($sformatf("read refusal %h", a), 16'h0000, {15'h0000, e});
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic xe);
    acc(1'b1, a, d);
    cmp($sformatf("refusal %h", a), {15'h0000, xe}, {15'h0000, e});
  endtask
  // high half first: the low write commits the pair, and the high read captures the low half for the low read
  task automatic rd2(input logic [15:0] a, input logic [31:0] x);
    rd(a, x[31:16]);
    rd(a + 16'h0001, x[15:0]);
  endtask
  task automatic wr2(input logic [15:0] a, input logic [31:0] x, input logic xe);
    wr(a, x[31:16], 1'b0);
    wr(a + 16'h0001, x[15:0], xe);
  endtask
  task automatic pulse(input int i);
    @(negedge clk);
    ev[i] = 1'b1;
    @(negedge clk);
    ev = 10'h000;
  endtask
  initial begin
    for (int i = 0; i < 9; i++) sv[i] = 16'h1100 + 16'(i);
    sv[4] = 16'h0001;
    sv[5] = 16'h0000;
    sv[6] = 16'hfff6;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 10; i++) repeat (i + 1) pulse(i);
    for (int i = 0; i < 10; i++) rd2(16'h0080 + 16'(2 * i), 32'(i + 1));
    wr2(16'h008c, 32'h000f423f, 1'b0);
    rd2(16'h008c, 32'h000f423f);
    wr2(16'h008c, 32'h000f4240, 1'b1);
    rd2(16'h008c, 32'h000f423f);
    wr2(16'h0092, 32'h00012345, 1'b0);
    rd2(16'h0092, 32'h00012345);
    wr2(16'h0086, 32'h00000000, 1'b0);
    pulse(3);
    rd2(16'h0086, 32'h00000001);
    wr2(16'h0082, 32'h12345678, 1'b0);
    rd2(16'h0082, 32'h12345678);
    wr(16'h0090, 16'h0000, 1'b1);
    wr(16'h0091, 16'h0000, 1'b1);
    rd2(16'h0090, 32'h00000009);
    for (int i = 0; i < 9; i++) rd(16'h0094 + 16'(i), sv[i]);
    @(negedge clk);
    sv[4] = 16'h0000;
    sv[5] = 16'h0001;
    rd(16'h0098, 16'h0000);
    rd(16'h0099, 16'h0001);
    for (int i = 0; i < 9; i++) wr(16'h0094 + 16'(i), 16'h0001, 1'b1);
    wr(16'h007f, 16'h0000, 1'b1);
    wr(16'h009d, 16'h0000, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
